/* File: rtl/fcbi_consts.svh */
`ifndef FCBI_CONSTS_SVH
`define FCBI_CONSTS_SVH
// Summary of operation
// - Hold power-down reset low at least 100ns
// - Wait recovery interval before next command
// - Never output and write enable low together
// - Block erase is 20H then D0H
// - Chip erase is 30H then D0H
// - Multi write E8H, count, pairs, D0H
// - Suspend is B0H at any address
// - D0H resumes and confirms
// - Only listed command codes are written

// Register byte offsets on the bus
`define FCBI_REG_CTRL    8'h00
`define FCBI_REG_ADDR    8'h04
`define FCBI_REG_WDATA   8'h08
`define FCBI_REG_RDATA   8'h0c
`define FCBI_REG_STATUS  8'h10
`define FCBI_REG_CFG     8'h14

// Control register bits
`define FCBI_CTRL_WR     0
`define FCBI_CTRL_RD     1
`define FCBI_CTRL_PD     2
`define FCBI_CTRL_CMD    3

// Status register bits
`define FCBI_ST_BUSY     0
`define FCBI_ST_PIN      1
`define FCBI_ST_ERR_CMD  2
`define FCBI_ST_ERR_BUSY 3

// Reset values
`define FCBI_CFG_RST     1'b0

// Command codes
`define FCBI_CMD_READ_ARRAY  8'hff
`define FCBI_CMD_IDENT       8'h90
`define FCBI_CMD_QUERY       8'h98
`define FCBI_CMD_READ_STAT   8'h70
`define FCBI_CMD_CLR_STAT    8'h50
`define FCBI_CMD_BLK_ERASE   8'h20
`define FCBI_CMD_CHIP_ERASE  8'h30
`define FCBI_CMD_WRITE       8'h40
`define FCBI_CMD_WRITE_ALT   8'h10
`define FCBI_CMD_MULTI       8'he8
`define FCBI_CMD_SUSPEND     8'hb0
`define FCBI_CMD_CONFIRM     8'hd0
`define FCBI_CMD_LOCK        8'h60
`define FCBI_CMD_STS_CFG     8'hb8

// Timing
`define FCBI_CLK_MHZ     20
`define FCBI_T_PD_NS     100
`define FCBI_T_WE_NS     100
`define FCBI_T_ACC_NS    150
`define FCBI_PD_CYC      ((`FCBI_T_PD_NS * `FCBI_CLK_MHZ + 999) / 1000)
`define FCBI_WE_CYC      ((`FCBI_T_WE_NS * `FCBI_CLK_MHZ + 999) / 1000)
`define FCBI_ACC_CYC     ((`FCBI_T_ACC_NS * `FCBI_CLK_MHZ + 999) / 1000)
`define FCBI_SYNC_CYC    3
`endif

/* File: rtl/fcbi_pkg.sv */
package fcbi_pkg;
  typedef struct packed {
    logic chip_select0_n;
    logic chip_select1_n;
    logic output_enable_n;
    logic write_enable_n;
    logic powerdown_reset_n;
  } fcbi_ctl_t;

  typedef enum logic [2:0] {
    FCBI_IDLE     = 3'b000,
    FCBI_WR_SETUP = 3'b001,
    FCBI_WR_STRB  = 3'b010,
    FCBI_WR_HOLD  = 3'b011,
    FCBI_RD_STRB  = 3'b100,
    FCBI_RD_END   = 3'b101,
    FCBI_PD_LOW   = 3'b110,
    FCBI_PD_WAKE  = 3'b111
  } fcbi_state_t;
endpackage : fcbi_pkg

/* File: rtl/fcbi_sync.sv */
`timescale 1ns/1ps
module fcbi_sync #(
  parameter int W = 17
) (
  input  wire logic         REF_CLK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          meta_r <= 1'b0;
          Q[i]   <= 1'b0;
        end else begin
          meta_r <= D[i];
          Q[i]   <= meta_r;
        end
      end
    end
  endgenerate
endmodule : fcbi_sync

/* File: rtl/fcbi_host.sv */
`timescale 1ns/1ps
`include "fcbi_consts.svh"
module fcbi_host
  import fcbi_pkg::*;
#(
  parameter int WAKE_READ_NS  = 1000,
  parameter int WAKE_WRITE_NS = 1000
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] HRDATA,
  output fcbi_ctl_t        FLASH_CTL,
  output logic      [21:0] FLASH_ADDR,
  output logic             WRITE_PROTECT_N,
  input  wire logic [15:0] DQ_I,
  output logic      [15:0] DQ_O,
  output logic             DQ_OE_N,
  input  wire logic        READY_STATUS_PIN
);
  localparam int WAKE_NS  = (WAKE_READ_NS > WAKE_WRITE_NS) ? WAKE_READ_NS : WAKE_WRITE_NS;
  localparam int WAKE_CYC = (WAKE_NS * `FCBI_CLK_MHZ + 999) / 1000;
  localparam int RD_CYC   = `FCBI_ACC_CYC + `FCBI_SYNC_CYC;

  function automatic logic fcbi_legal_cmd(input logic [7:0] code);
    case (code)
      `FCBI_CMD_READ_ARRAY, `FCBI_CMD_IDENT, `FCBI_CMD_QUERY, `FCBI_CMD_READ_STAT,
      `FCBI_CMD_CLR_STAT, `FCBI_CMD_WRITE, `FCBI_CMD_WRITE_ALT, `FCBI_CMD_LOCK,
      `FCBI_CMD_STS_CFG,
      `FCBI_CMD_BLK_ERASE, `FCBI_CMD_CHIP_ERASE,
      `FCBI_CMD_MULTI, `FCBI_CMD_SUSPEND,
      `FCBI_CMD_CONFIRM: fcbi_legal_cmd = 1'b1;
      default: fcbi_legal_cmd = 1'b0;
    endcase
  endfunction : fcbi_legal_cmd

  fcbi_state_t state_r;
  fcbi_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  fcbi_ctl_t   ctl_nxt;
  logic        ph_wr_r;
  logic        ph_rd_r;
  logic [7:0]  ph_addr_r;
  logic [21:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic        cfg_wp_r;
  logic        err_cmd_r;
  logic        err_busy_r;
  logic [16:0] sync_q;
  logic        wr_ctrl;
  logic        go_wr;
  logic        go_rd;
  logic        go_pd;
  logic        bad_cmd;
  logic        idle;
  logic [15:0] since_rp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flops before use
  fcbi_sync #(.W(17)) u_sync (
    .REF_CLK (REF_CLK),
    .RST_N   (RST_N),
    .D       ({READY_STATUS_PIN, DQ_I}),
    .Q       (sync_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, zero wait states
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign idle      = (state_r == FCBI_IDLE);
  assign wr_ctrl   = ph_wr_r && (ph_addr_r == `FCBI_REG_CTRL);
  assign bad_cmd   = HWDATA[`FCBI_CTRL_CMD] && !fcbi_legal_cmd(wdata_r[7:0]);
  assign go_pd     = wr_ctrl && idle && HWDATA[`FCBI_CTRL_PD];
  assign go_wr     = wr_ctrl && idle && HWDATA[`FCBI_CTRL_WR] && !bad_cmd;
  assign go_rd     = wr_ctrl && idle && HWDATA[`FCBI_CTRL_RD];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (HREADY) begin
      ph_wr_r   <= HSEL && HTRANS[1] && HWRITE;
      ph_rd_r   <= HSEL && HTRANS[1] && !HWRITE;
      ph_addr_r <= HADDR[7:0];
    end
  end

  // Read data is sampled in the address phase, so a write in the
  // preceding data phase is not yet visible
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        `FCBI_REG_ADDR:   HRDATA <= {10'h000, addr_r};
        `FCBI_REG_WDATA:  HRDATA <= {16'h0000, wdata_r};
        `FCBI_REG_RDATA:  HRDATA <= {16'h0000, rdata_r};
        `FCBI_REG_STATUS: HRDATA <= {28'h000_0000, err_busy_r, err_cmd_r, sync_q[16], !idle};
        `FCBI_REG_CFG:    HRDATA <= {31'h0000_0000, cfg_wp_r};
        default:          HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_r   <= 22'h00_0000;
      wdata_r  <= 16'h0000;
      cfg_wp_r <= `FCBI_CFG_RST;
    end else if (ph_wr_r) begin
      if (ph_addr_r == `FCBI_REG_ADDR) addr_r <= HWDATA[21:0];
      if (ph_addr_r == `FCBI_REG_WDATA) wdata_r <= HWDATA[15:0];
      if (ph_addr_r == `FCBI_REG_CFG) cfg_wp_r <= HWDATA[0];
    end
  end

  // Sticky errors, write one to clear; a new error wins over the clear
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_cmd_r  <= 1'b0;
      err_busy_r <= 1'b0;
    end else begin
      if (wr_ctrl && idle && HWDATA[`FCBI_CTRL_WR] && !HWDATA[`FCBI_CTRL_PD] && bad_cmd)
        err_cmd_r <= 1'b1;
      else if (ph_wr_r && ph_addr_r == `FCBI_REG_STATUS && HWDATA[`FCBI_ST_ERR_CMD])
        err_cmd_r <= 1'b0;
      if (wr_ctrl && !idle && (HWDATA[2:0] != 3'h0))
        err_busy_r <= 1'b1;
      else if (ph_wr_r && ph_addr_r == `FCBI_REG_STATUS && HWDATA[`FCBI_ST_ERR_BUSY])
        err_busy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer; reset also resets the flash
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 16'h0001;
    unique case (state_r)
      FCBI_IDLE: begin
        cnt_nxt = 16'h0000;
        if (go_pd) state_nxt = FCBI_PD_LOW;
        else if (go_wr) state_nxt = FCBI_WR_SETUP;
        else if (go_rd) state_nxt = FCBI_RD_STRB;
      end
      FCBI_WR_SETUP: begin
        cnt_nxt   = 16'h0000;
        state_nxt = FCBI_WR_STRB;
      end
      FCBI_WR_STRB: begin
        if (cnt_r == 16'(`FCBI_WE_CYC - 1)) state_nxt = FCBI_WR_HOLD;
      end
      FCBI_WR_HOLD: state_nxt = FCBI_IDLE;
      FCBI_RD_STRB: begin
        if (cnt_r == 16'(RD_CYC - 1)) state_nxt = FCBI_RD_END;
      end
      FCBI_RD_END: state_nxt = FCBI_IDLE;
      FCBI_PD_LOW: begin
        if (cnt_r == 16'(`FCBI_PD_CYC - 1)) begin
          cnt_nxt   = 16'h0000;
          state_nxt = FCBI_PD_WAKE;
        end
      end
      FCBI_PD_WAKE: begin
        if (cnt_r == 16'(WAKE_CYC - 1)) state_nxt = FCBI_IDLE;
      end
    endcase
  end

  always_comb begin
    ctl_nxt.powerdown_reset_n = (state_nxt != FCBI_PD_LOW);
    ctl_nxt.chip_select0_n    = !(state_nxt inside {FCBI_WR_SETUP, FCBI_WR_STRB,
                                                    FCBI_WR_HOLD, FCBI_RD_STRB});
    ctl_nxt.chip_select1_n    = ctl_nxt.chip_select0_n;
    ctl_nxt.write_enable_n    = (state_nxt != FCBI_WR_STRB);
    ctl_nxt.output_enable_n   = (state_nxt != FCBI_RD_STRB);
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r   <= FCBI_PD_LOW;
      cnt_r     <= 16'h0000;
      FLASH_CTL <= 5'h1e;
      DQ_OE_N   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      FLASH_CTL <= ctl_nxt;
      DQ_OE_N   <= !(state_nxt inside {FCBI_WR_SETUP, FCBI_WR_STRB, FCBI_WR_HOLD});
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLASH_ADDR <= 22'h00_0000;
      DQ_O       <= 16'h0000;
    end else if (go_wr || go_rd) begin
      FLASH_ADDR <= addr_r;
      DQ_O       <= wdata_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= 16'h0000;
    end else if (state_r == FCBI_RD_STRB && cnt_r == 16'(RD_CYC - 1)) begin
      rdata_r <= sync_q[15:0];
    end
  end

  assign WRITE_PROTECT_N = cfg_wp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) since_rp_r <= 16'h0000;
    else if (!FLASH_CTL.powerdown_reset_n) since_rp_r <= 16'h0000;
    else if (since_rp_r != 16'hffff) since_rp_r <= since_rp_r + 16'h0001;
  end

  property p_oe_we_excl;
    @(posedge REF_CLK) disable iff (!RST_N)
      !(FLASH_CTL.output_enable_n == 1'b0 && FLASH_CTL.write_enable_n == 1'b0);
  endproperty
  a_oe_we_excl: assert property (p_oe_we_excl) else $error("OE and WE low together");

  property p_pd_min;
    @(posedge REF_CLK) disable iff (!RST_N)
      $rose(FLASH_CTL.powerdown_reset_n) |->
        !$past(FLASH_CTL.powerdown_reset_n, 1) && !$past(FLASH_CTL.powerdown_reset_n, 2);
  endproperty
  a_pd_min: assert property (p_pd_min) else $error("Power-down pulse too short");

  property p_wake;
    @(posedge REF_CLK) disable iff (!RST_N)
      !FLASH_CTL.chip_select0_n |-> (since_rp_r >= 16'(WAKE_CYC));
  endproperty
  a_wake: assert property (p_wake) else $error("Access before wake-up");

  property p_we_in_ce;
    @(posedge REF_CLK) disable iff (!RST_N)
      !FLASH_CTL.write_enable_n |-> !FLASH_CTL.chip_select0_n && !FLASH_CTL.chip_select1_n;
  endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("WE low without CE");

  property p_we_first;
    @(posedge REF_CLK) disable iff (!RST_N)
      $rose(FLASH_CTL.write_enable_n) |->
        !FLASH_CTL.chip_select0_n && !DQ_OE_N ##1 FLASH_CTL.chip_select0_n;
  endproperty
  a_we_first: assert property (p_we_first) else $error("WE did not rise first");

  property p_we_width;
    @(posedge REF_CLK) disable iff (!RST_N)
      $fell(FLASH_CTL.write_enable_n) |-> !FLASH_CTL.write_enable_n[*2] ##1 FLASH_CTL.write_enable_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("WE width wrong");

  property p_no_drive_read;
    @(posedge REF_CLK) disable iff (!RST_N)
      !FLASH_CTL.output_enable_n |-> DQ_OE_N;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) else $error("Driving DQ in read");

  property p_oe_toggle;
    @(posedge REF_CLK) disable iff (!RST_N)
      $rose(FLASH_CTL.output_enable_n) |-> FLASH_CTL.output_enable_n ##1 FLASH_CTL.output_enable_n;
  endproperty
  a_oe_toggle: assert property (p_oe_toggle) else $error("OE high too briefly");

  property p_bad_cmd;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wr_ctrl && idle && HWDATA[`FCBI_CTRL_WR] && !HWDATA[`FCBI_CTRL_PD] && bad_cmd) |=>
        (state_r == FCBI_IDLE) && err_cmd_r && FLASH_CTL.write_enable_n;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("Reserved code not refused");
endmodule : fcbi_host

/* File: testbench/fcbi_flash_model.sv */
`timescale 1ns/1ps
module fcbi_flash_model
  import fcbi_pkg::*;
#(
  parameter int         BUSY_NS = 5000,
  parameter logic [7:0] MAKER   = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART    = 8'h3c  // Arbitrary value
) (
  input  wire fcbi_ctl_t   ctl,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] din,
  input  wire logic        wp_n,
  output logic      [15:0] dout,
  output logic             sts
);
  logic [7:0]  sr_r   = 8'h80;
  logic [7:0]  lat_r  = 8'h80;
  logic [7:0]  p_r    = 8'h00;
  logic [1:0]  mode_r = 2'd0;
  logic [63:0] lock_r = '0;
  logic        busy_r = 1'b0;
  logic        lvl_r  = 1'b1;
  logic [15:0] last_r = 16'h0000;
  event        go_e;
  wire sel = !ctl.chip_select0_n && !ctl.chip_select1_n && ctl.powerdown_reset_n;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rd(input logic [21:0] a);
    case (mode_r)
      2'd0:    rd = a[15:0] ^ 16'ha5c3;
      2'd1:    rd = {8'h00, a[1] ? {7'h00, lock_r[a[21:16]]} : (a[0] ? PART : MAKER)};
      2'd2:    rd = {8'h00, a[5:0] == 6'h10 ? 8'h51 : (a[5:0] == 6'h11 ? 8'h52 : 8'h00)};
      default: rd = {8'h00, lat_r};
    endcase
  endfunction : rd
  // Released lines show the inverse of the last value, no keeper on this bus
  always @(ctl or addr or mode_r or lat_r or lock_r) begin
    if (sel && !ctl.output_enable_n) begin
      dout   = rd(addr);
      last_r = dout;
    end else
      dout = ~last_r;
  end
  always @(negedge ctl.output_enable_n) lat_r = sr_r;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic start(input logic [21:0] a);
    if (lock_r[a[21:16]] && !wp_n) sr_r[4] = 1'b1;
    else ->go_e;
  endtask : start
  always @(posedge ctl.write_enable_n) if (sel) begin
    if (p_r != 8'h00) begin
      if (p_r == 8'h40 || p_r == 8'h10) start(addr);
      else if ((p_r == 8'h20 || p_r == 8'h30) && din[7:0] == 8'hd0) start(addr);
      else if (p_r == 8'h60 && din[7:0] == 8'h01) lock_r[addr[21:16]] = 1'b1;
      else if (p_r == 8'h60 && din[7:0] == 8'hd0 && wp_n) lock_r = '0;
      else if (p_r == 8'hb8) lvl_r = (din[7:0] == 8'h00);
      p_r = 8'h00;
    end else case (din[7:0])
      8'hff:   if (!busy_r) mode_r = 2'd0;
      8'h90:   mode_r = 2'd1;
      8'h98:   mode_r = 2'd2;
      8'h70:   mode_r = 2'd3;
      8'h50:   sr_r = sr_r & 8'hc5;
      default: begin
        p_r    = din[7:0];
        mode_r = 2'd3;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(go_e) begin : write_state_machine
    busy_r  = 1'b1;
    sr_r[7] = 1'b0;
    #(BUSY_NS);
    busy_r  = 1'b0;
    sr_r[7] = 1'b1;
  end
  always @(negedge ctl.powerdown_reset_n) begin
    disable write_state_machine;
    busy_r = 1'b0;
    sr_r   = 8'h80;
    mode_r = 2'd0;
    p_r    = 8'h00;
  end
  // Pull-up on the pin: floats high unless busy in level mode
  assign sts = !(busy_r && lvl_r && ctl.powerdown_reset_n);
endmodule : fcbi_flash_model

/* File: testbench/test_flash_command_bus_interface.sv */
`timescale 1ns/1ps
module test_flash_command_bus_interface
  import fcbi_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = '0;
  logic [31:0] hwdata  = '0;
  logic [1:0]  htrans  = '0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, wp_n, dq_oe_n, sts;
  fcbi_ctl_t   flash_ctl;
  logic [21:0] flash_addr;
  logic [15:0] dq_o, m_dq, dq_i;
  int          n_errors    = 0;
  int          check_count = 0;
  assign dq_i = dq_oe_n ? m_dq : dq_o;
  initial forever #25 ref_clk = ~ref_clk;
  fcbi_host #(.WAKE_READ_NS(100), .WAKE_WRITE_NS(100)) uut (.REF_CLK(ref_clk), .RST_N(rst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
    .FLASH_CTL(flash_ctl), .FLASH_ADDR(flash_addr), .WRITE_PROTECT_N(wp_n), .DQ_I(dq_i),
    .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .READY_STATUS_PIN(sts));
  fcbi_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.ctl(flash_ctl), .addr(flash_addr),
    .din(dq_o), .wp_n(wp_n), .dout(m_dq), .sts(sts));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for the slave; a stuck bus ends the run as a mismatch
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t bus never ready", $time);
      end_of_test();
    end
  endtask : wait_ready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : ahb
  // Controller sets busy at the data-phase edge of the control write; one more edge passes before polling
  task automatic wait_idle;
    logic [31:0] r;
    int          k;
    k = 0;
    @(posedge ref_clk);
    do begin
      ahb(1'b0, 8'h10, 0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_errors++;
      $display("[ERR] %0t controller stays busy", $time);
      end_of_test();
    end
  endtask : wait_idle
  task automatic fw(input logic [15:0] d, input logic [21:0] a, input logic [3:0] c);
    logic [31:0] r;
    ahb(1'b1, 8'h04, {10'h0, a}, r);
    ahb(1'b1, 8'h08, {16'h0, d}, r);
    ahb(1'b1, 8'h00, {28'h0, c}, r);
    wait_idle();
  endtask : fw
  task automatic fr(input logic [21:0] a, output logic [31:0] d);
    ahb(1'b1, 8'h04, {10'h0, a}, d);
    ahb(1'b1, 8'h00, 32'h2, d);
    wait_idle();
    ahb(1'b0, 8'h0c, 0, d);
  endtask : fr
  function automatic logic [31:0] exp_arr(input logic [21:0] a);
    return {16'h0, a[15:0] ^ 16'ha5c3};
  endfunction : exp_arr
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [21:0] a;
    logic [7:0]  codes [14] = '{8'hff, 8'h90, 8'h98, 8'h70, 8'h50, 8'h20, 8'h30, 8'h40,
                                8'h10, 8'he8, 8'hb0, 8'hd0, 8'h60, 8'hb8};
    void'($urandom(32'h0c2a1f0f));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_idle();
    ahb(1'b0, 8'h14, 0, r);
    chk(r, 0);
    chk({31'h0, wp_n}, 0);
    ahb(1'b0, 8'h20, 0, r);
    chk(r, 0);
    chk({31'h0, hresp}, 0);
    ahb(1'b1, 8'h14, 1, r);
    // The pin register updates at the data-phase edge; look one edge later
    @(posedge ref_clk);
    chk({31'h0, wp_n}, 1);
    $display("registers done");
    repeat (6) begin
      a = 22'($urandom);
      fr(a, r);
      chk(r, exp_arr(a));
    end
    fw(16'h90, 0, 4'h9);
    fr(0, r);
    chk(r, {24'h0, MAKER});
    fr(1, r);
    chk(r, {24'h0, PART});
    fw(16'h98, 0, 4'h9);
    fr(22'h10, r);
    chk(r, 32'h51);
    fr(22'h11, r);
    chk(r, 32'h52);
    fw(16'h70, 0, 4'h9);
    fr(a, r);
    chk(r, 32'h80);
    $display("read modes done");
    foreach (codes[i]) fw({8'h00, codes[i]}, 0, 4'h9);
    ahb(1'b0, 8'h10, 0, r);
    chk(r[3:2], 0);
    fw(16'h33, 0, 4'h9);
    ahb(1'b0, 8'h10, 0, r);
    chk(r[2], 1);
    ahb(1'b1, 8'h10, 32'hc, r);
    ahb(1'b1, 8'h00, 32'h4, r);
    wait_idle();
    $display("command codes done");
    a = 22'($urandom);
    fw(16'h40, a, 4'h9);
    fw(16'($urandom), a, 4'h1);
    fr(a, r);
    chk(r, 0);
    ahb(1'b0, 8'h10, 0, r);
    chk(r[1], 0);
    ahb(1'b1, 8'h00, 32'h2, r);
    ahb(1'b1, 8'h00, 32'h2, r);
    ahb(1'b0, 8'h10, 0, r);
    chk(r[3], 1);
    ahb(1'b1, 8'h10, 32'hc, r);
    wait_idle();
    fw(16'hff, 0, 4'h9);
    fr(a, r);
    chk(r, 0);
    ahb(1'b1, 8'h00, 32'h4, r);
    wait_idle();
    fr(a, r);
    chk(r, exp_arr(a));
    ahb(1'b0, 8'h10, 0, r);
    chk(r[1], 1);
    $display("abort done");
    fw(16'h60, a, 4'h9);
    fw(16'h01, a, 4'h1);
    ahb(1'b1, 8'h14, 0, r);
    fw(16'h10, a, 4'h9);
    fw(16'h1234, a, 4'h1);
    fr(a, r);
    chk(r, 32'h90);
    fw(16'h50, 0, 4'h9);
    fr(a, r);
    chk(r, 32'h80);
    fw(16'h90, 0, 4'h9);
    fr({a[21:16], 16'h0002}, r);
    chk(r, 1);
    ahb(1'b1, 8'h14, 1, r);
    fw(16'h60, 0, 4'h9);
    fw(16'hd0, 0, 4'h9);
    fw(16'h90, 0, 4'h9);
    fr({a[21:16], 16'h0002}, r);
    chk(r, 0);
    $display("locking done");
    fw(16'hb8, 0, 4'h9);
    fw(16'h01, 0, 4'h1);
    for (int i = 0; i < 2; i++) begin
      fw(i ? 16'h30 : 16'h20, a, 4'h9);
      fw(16'hd0, a, 4'h9);
      fr(a, r);
      chk(r, 0);
      ahb(1'b0, 8'h10, 0, r);
      // Pulse mode first: the pin stays released while busy; level mode pulls it low
      chk(r[1], i ? 0 : 1);
      fw(16'hb8, 0, 4'h9);
      fw(16'h00, 0, 4'h1);
      repeat (110) @(posedge ref_clk);
      fr(a, r);
      chk(r, 32'h80);
    end
    $display("erase done");
    end_of_test();
  end
endmodule : test_flash_command_bus_interface
